//--- rfc_pkg.sv
// Constants and carrier types of the frame and receiver control block
package rfc_pkg;
	// Register indices; the byte address is four times the index
	localparam logic [7:0] IDX_FRAME = 8'h33;
	localparam logic [7:0] IDX_SOFD = 8'h34;
	localparam logic [7:0] IDX_RECEIVE_CONTROL = 8'h35;
	localparam logic [7:0] IDX_BLANKING_COUNT = 8'h36;
	localparam logic [7:0] RST_REG = 8'h00;
	localparam logic [7:0] FRAME_WMASK = 8'hCF;
	localparam logic [7:0] SOFD_WMASK = 8'h24;
	// Frame control fields
	localparam int FC_TXPAR = 7;
	localparam int FC_RXPAR = 6;
	localparam int FC_STOP = 2;
	localparam int FC_START = 0;
	// Start detect status fields
	localparam int SD_SOF_EN = 5;
	localparam int SD_SOF_SEEN = 4;
	localparam int SD_SUBCARRIER_EVENT_ENABLE = 2;
	localparam int SD_SUBC_SEEN = 1;
	localparam int SD_SUBC_LIVE = 0;
	// Receive control fields
	localparam int RC_ALLOW = 7;
	localparam int RC_MULTI = 6;
	localparam int RC_EOF_B = 5;
	localparam int RC_EGT = 4;
	localparam int RC_EMD = 3;
	localparam int RC_BAUD = 0;
	// Blanking time fields
	localparam int RW_UNIT = 7;
	localparam int RW_COUNT = 0;
	// Receive baud codes in range
	localparam logic [2:0] BAUD_MIN = 3'h2;
	localparam logic [2:0] BAUD_MAX = 3'h7;
	localparam logic [1:0] EMD_BYTES = 2'h3;
	// Timing: clock and carrier in kHz, units in carrier cycles
	localparam logic [17:0] CLK_KHZ = 18'h30D40;
	localparam logic [17:0] CARRIER_KHZ = 18'h034F8;
	localparam logic [10:0] UNIT_CARRIER = 11'h010;
	localparam logic [10:0] HALF_BIT_FASTEST = 11'h008;
	typedef enum logic [1:0] {
		SYM_DATA = 2'h0,
		SYM_0 = 2'h1,
		SYM_1 = 2'h2,
		SYM_2 = 2'h3
	} rfc_kind_type;
	typedef struct packed {
		logic valid;
		rfc_kind_type kind;
		logic bit_val;
	} rfc_sym_type;
	typedef struct packed {
		logic wr;
		logic [7:0] data;
	} rfc_fifo_type;
	typedef struct packed {
		logic bit_valid;
		logic bit_val;
		logic sof;
		logic eof;
		logic coll;
		logic err;
	} rfc_rxin_type;
	typedef enum logic [4:0] {
		TX_LOAD = 5'h01,
		TX_START = 5'h02,
		TX_DATA = 5'h04,
		TX_PAR = 5'h08,
		TX_STOP = 5'h10
	} rfc_tx_state_type;
endpackage : rfc_pkg

//--- rfc_frame_rx_ctrl.sv
// Frame and receiver control with its register slave
// Behaviour
// - Transmit parity enabled: odd parity bit follows every transmitted byte.
// - Receive parity enabled: check parity, never store parity bits.
// - Stop field 0 sends nothing; 1..3 send symbol 0..2 at frame end.
// - Start field 0 sends nothing; 1..3 send symbol 0..2 at frame start.
// - Start-of-frame with its enable set raises the frame start request.
// - Start-of-frame sets a sticky seen flag until software clears it.
// - Subcarrier with its enable set raises the same frame start request.
// - Subcarrier sets a sticky seen flag until software clears it.
// - Read-only live bit shows the subcarrier is present now.
// - Partial bytes allowed: incomplete last byte is still written.
// - Multiple reception: receiver keeps running after each frame.
// - Multiple reception: error register copy appended after each frame that is not suppressed.
// - Frame end type 0 expects pattern end, 1 expects type B end.
// - End check off when type 0 and pattern low bits are zero.
// - Guard check on: too long extra guard time flags protocol error.
// - Suppression on: error in first three bytes discards them, resets FIFO.
// - Suppression on: collision is an error, short frame is an error.
// - Suppressed frame raises no receive complete request.
// - Receive baud codes 2..7 select 26 to 847 kBd; 0, 1 reserved.
// - Blanking unit is 16 carrier cycles or half a data bit.
// - After transmit end all rx_in and egt_in input is ignored for blanking count; subc_in detection is not blanked.
// - Half bit unit uses the transmit bit rate.
module rfc_frame_rx_ctrl
	import rfc_pkg::*;
#(
	parameter int EGT_LIMIT = 1024
) (
	input wire logic clk_in,
	input wire logic srst_in,
	input wire logic [7:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	input wire logic [3:0] avs_byteenable_in,
	output logic [31:0] avs_readdata_out,
	output logic avs_waitrequest_out,
	input wire logic tx_valid_in,
	input wire logic [7:0] tx_data_in,
	input wire logic tx_last_in,
	input wire logic [2:0] tx_baud_in,
	output logic tx_ready_out,
	output rfc_sym_type tx_sym_out,
	input wire logic rx_start_in,
	input wire rfc_rxin_type rx_in,
	input wire logic subc_in,
	input wire logic egt_in,
	input wire logic [1:0] eof_pattern_in,
	input wire logic [7:0] error_reg_in,
	output rfc_fifo_type fifo_out,
	output logic fifo_reset_out,
	output logic rx_done_irq_out,
	output logic frame_start_irq_out,
	output logic proto_err_out,
	output logic parity_err_out,
	output logic eof_check_out,
	output logic eof_type_b_out,
	output logic [2:0] rx_baud_out,
	output logic rx_baud_ok_out,
	output logic rx_busy_out,
	output logic blank_out
);
	localparam int EW = $clog2(EGT_LIMIT + 1);
	generate
		if (EGT_LIMIT < 2) begin : g_chk
			$error("EGT_LIMIT must be at least 2");
		end
	endgenerate

	// ****************
	// Register slave
	// ****************
	logic wait_q, wait_d;
	logic [7:0] frame_q, receive_control_q, blanking_count_q, rd8_q, rd8_d;
	logic sof_en_q, subcarrier_event_enable_q, sof_seen_q, subc_seen_q, live_q;
	wire req = avs_read_in | avs_write_in;
	wire take = req & ~wait_q;
	wire wr0 = take & avs_write_in & avs_byteenable_in[0];
	wire [7:0] wd = avs_writedata_in[7:0];
	wire hit_frame = avs_address_in == {IDX_FRAME[5:0], 2'h0};
	wire hit_sofd = avs_address_in == {IDX_SOFD[5:0], 2'h0};
	wire hit_receive_control = avs_address_in == {IDX_RECEIVE_CONTROL[5:0], 2'h0};
	wire hit_blanking_count = avs_address_in == {IDX_BLANKING_COUNT[5:0], 2'h0};
	wire [7:0] sofd_rd = {2'h0, sof_en_q, sof_seen_q, 1'h0, subcarrier_event_enable_q, subc_seen_q, live_q};
	assign wait_d = ~(req & wait_q);

	always_comb begin
		if (hit_frame) begin
			rd8_d = frame_q & FRAME_WMASK;
		end else if (hit_sofd) begin
			rd8_d = sofd_rd;
		end else if (hit_receive_control) begin
			rd8_d = receive_control_q;
		end else if (hit_blanking_count) begin
			rd8_d = blanking_count_q;
		end else begin
			rd8_d = 8'h00;
		end
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			wait_q <= 1'b1;
			rd8_q <= 8'h00;
			frame_q <= RST_REG;
			receive_control_q <= RST_REG;
			blanking_count_q <= RST_REG;
			sof_en_q <= 1'b0;
			subcarrier_event_enable_q <= 1'b0;
		end else begin
			wait_q <= wait_d;
			rd8_q <= rd8_d;
			if (wr0 && hit_frame) frame_q <= wd & FRAME_WMASK;
			if (wr0 && hit_receive_control) receive_control_q <= wd;
			if (wr0 && hit_blanking_count) blanking_count_q <= wd;
			if (wr0 && hit_sofd) begin
				sof_en_q <= wd[SD_SOF_EN];
				subcarrier_event_enable_q <= wd[SD_SUBCARRIER_EVENT_ENABLE];
			end
		end
	end
	assign avs_waitrequest_out = wait_q;
	assign avs_readdata_out = {24'h000000, rd8_q};

	AST_BUS_ONE_WAIT: assert property (@(posedge clk_in) disable iff (srst_in)
		req && wait_q |=> !wait_q ##1 wait_q) else $error("bus answer not one cycle");

	// ****************
	// Control fields
	// ****************
	wire txpar_en = frame_q[FC_TXPAR];
	wire rxpar_en = frame_q[FC_RXPAR];
	wire [1:0] stop_code = frame_q[FC_STOP +: 2];
	wire [1:0] start_code = frame_q[FC_START +: 2];
	wire allow_part = receive_control_q[RC_ALLOW];
	wire multi_en = receive_control_q[RC_MULTI];
	wire eof_b = receive_control_q[RC_EOF_B];
	wire egt_chk = receive_control_q[RC_EGT];
	wire emd_en = receive_control_q[RC_EMD];
	wire [2:0] baud = receive_control_q[RC_BAUD +: 3];
	wire unit_half = blanking_count_q[RW_UNIT];
	wire [6:0] blank_cnt = blanking_count_q[RW_COUNT +: 7];

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			eof_check_out <= 1'b0;
			eof_type_b_out <= 1'b0;
			rx_baud_out <= 3'h0;
			rx_baud_ok_out <= 1'b0;
		end else begin
			eof_check_out <= eof_b | (|eof_pattern_in);
			eof_type_b_out <= eof_b;
			rx_baud_out <= baud;
			rx_baud_ok_out <= baud >= BAUD_MIN && baud <= BAUD_MAX;
		end
	end

	AST_BAUD_RANGE: assert property (@(posedge clk_in) disable iff (srst_in)
		baud < BAUD_MIN |=> !rx_baud_ok_out) else $error("reserved baud accepted");

	// ****************
	// Transmit framer
	// ****************
	rfc_tx_state_type tx_q;
	logic [7:0] tbyte_q;
	logic [2:0] tcnt_q;
	logic tlast_q, first_q, tx_end_q;
	wire end_stop = tlast_q && stop_code != 2'h0;
	wire end_now = tlast_q && stop_code == 2'h0;
	wire rfc_tx_state_type after_byte = end_stop ? TX_STOP : TX_LOAD;
	wire tpar = ~^tbyte_q;

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			tx_q <= TX_LOAD;
			tbyte_q <= 8'h00;
			tcnt_q <= 3'h0;
			tlast_q <= 1'b0;
			first_q <= 1'b1;
			tx_ready_out <= 1'b1;
			tx_sym_out <= '0;
			tx_end_q <= 1'b0;
		end else begin
			tx_sym_out <= '0;
			tx_end_q <= 1'b0;
			case (tx_q)
				TX_LOAD: begin
					if (tx_valid_in && tx_ready_out) begin
						tbyte_q <= tx_data_in;
						tlast_q <= tx_last_in;
						tcnt_q <= 3'h0;
						tx_ready_out <= 1'b0;
						first_q <= 1'b0;
						tx_q <= (first_q && start_code != 2'h0) ? TX_START : TX_DATA;
					end
				end
				TX_START: begin
					tx_sym_out <= {1'b1, rfc_kind_type'(start_code), 1'b0};
					tx_q <= TX_DATA;
				end
				TX_DATA: begin
					tx_sym_out <= {1'b1, SYM_DATA, tbyte_q[tcnt_q]};
					tcnt_q <= tcnt_q + 3'h1;
					if (tcnt_q == 3'h7) begin
						tx_q <= txpar_en ? TX_PAR : after_byte;
						tx_ready_out <= !txpar_en && !end_stop;
						first_q <= !txpar_en && end_now;
						tx_end_q <= !txpar_en && end_now;
					end
				end
				TX_PAR: begin
					tx_sym_out <= {1'b1, SYM_DATA, tpar};
					tx_q <= after_byte;
					tx_ready_out <= !end_stop;
					first_q <= end_now;
					tx_end_q <= end_now;
				end
				TX_STOP: begin
					tx_sym_out <= {1'b1, rfc_kind_type'(stop_code), 1'b0};
					tx_q <= TX_LOAD;
					tx_ready_out <= 1'b1;
					first_q <= 1'b1;
					tx_end_q <= 1'b1;
				end
				default: begin
					tx_q <= TX_LOAD;
					tx_ready_out <= 1'b1;
				end
			endcase
		end
	end

	AST_TX_PARITY: assert property (@(posedge clk_in) disable iff (srst_in)
		tx_q == TX_PAR |=> tx_sym_out.valid && tx_sym_out.bit_val == ~^$past(tbyte_q))
		else $error("parity bit wrong");
	AST_TX_START: assert property (@(posedge clk_in) disable iff (srst_in)
		tx_q == TX_START |=> tx_sym_out.kind == $past(frame_q[1:0])) else $error("start symbol wrong");
	AST_TX_STOP: assert property (@(posedge clk_in) disable iff (srst_in)
		tx_q == TX_STOP |=> tx_sym_out.kind == $past(frame_q[FC_STOP +: 2]) && tx_ready_out)
		else $error("stop symbol wrong");

	// ****************
	// Receive blanking
	// ****************
	logic [17:0] acc_q;
	logic [10:0] ucnt_q;
	logic [6:0] bcnt_q;
	wire [17:0] acc_sum = acc_q + CARRIER_KHZ;
	wire ctick = acc_sum >= CLK_KHZ;
	wire [10:0] half_bit = HALF_BIT_FASTEST << (BAUD_MAX - tx_baud_in);
	wire [10:0] unit_m1 = (unit_half ? half_bit : UNIT_CARRIER) - 11'h001;

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			acc_q <= 18'h00000;
			ucnt_q <= 11'h000;
			bcnt_q <= 7'h00;
			blank_out <= 1'b0;
		end else begin
			acc_q <= tx_end_q ? 18'h00000 : (ctick ? acc_sum - CLK_KHZ : acc_sum); // Phase restarts at transmit end
			if (tx_end_q) begin
				bcnt_q <= blank_cnt;
				ucnt_q <= unit_m1;
				blank_out <= blank_cnt != 7'h00;
			end else if (blank_out && ctick) begin
				ucnt_q <= ucnt_q - 11'h001;
				if (ucnt_q == 11'h000) begin
					ucnt_q <= unit_m1;
					bcnt_q <= bcnt_q - 7'h01;
					blank_out <= bcnt_q != 7'h01;
				end
			end
		end
	end

	AST_BLANK_START: assert property (@(posedge clk_in) disable iff (srst_in)
		tx_end_q && blanking_count_q[6:0] != 7'h00 |=> blank_out[*8]) else $error("blanking missing");

	// ****************
	// Start detection
	// ****************
	logic subc_s1_q, subc_s2_q, sof_ev;
	wire subc_ev = subc_s2_q & ~live_q;
	wire clr_sof = wr0 && hit_sofd && !wd[SD_SOF_SEEN];
	wire clr_subc = wr0 && hit_sofd && !wd[SD_SUBC_SEEN];

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			subc_s1_q <= 1'b0;
			subc_s2_q <= 1'b0;
			live_q <= 1'b0;
			sof_seen_q <= 1'b0;
			subc_seen_q <= 1'b0;
			frame_start_irq_out <= 1'b0;
		end else begin
			subc_s1_q <= subc_in;
			subc_s2_q <= subc_s1_q;
			live_q <= subc_s2_q;
			sof_seen_q <= sof_ev | (sof_seen_q & ~clr_sof);
			subc_seen_q <= subc_ev | (subc_seen_q & ~clr_subc);
			frame_start_irq_out <= (sof_ev & sof_en_q) | (subc_ev & subcarrier_event_enable_q);
		end
	end

	AST_SOF_SEEN: assert property (@(posedge clk_in) disable iff (srst_in)
		sof_ev |=> sof_seen_q ##1 (sof_seen_q || $past(clr_sof))) else $error("sof flag lost");
	AST_SOF_IRQ: assert property (@(posedge clk_in) disable iff (srst_in)
		sof_ev && sof_en_q |=> frame_start_irq_out) else $error("sof request missing");
	AST_SUBC_IRQ: assert property (@(posedge clk_in) disable iff (srst_in)
		subc_ev && subcarrier_event_enable_q |=> frame_start_irq_out && subc_seen_q) else $error("subcarrier request missing");
	AST_LIVE: assert property (@(posedge clk_in) disable iff (srst_in)
		subc_in ##1 subc_in ##1 subc_in |=> live_q) else $error("live bit late");

	// ****************
	// Receive path
	// ****************
	logic [7:0] shift_q;
	logic [3:0] bitcnt_q;
	logic [1:0] nbytes_q;
	logic [EW-1:0] egt_q;
	logic err_pend_q;
	wire accept = rx_busy_out & ~blank_out;
	assign sof_ev = accept & rx_in.sof;
	wire bitv = accept & rx_in.bit_valid;
	wire par_slot = bitcnt_q == 4'h8;
	wire par_bad = bitv && par_slot && rx_in.bit_val != ~^shift_q;
	wire egt_err = accept && egt_chk && egt_in && egt_q == EW'(EGT_LIMIT - 1);
	wire err_now = accept && (rx_in.err || (emd_en && rx_in.coll)) || par_bad || egt_err;
	wire few = nbytes_q < EMD_BYTES;
	wire kill = emd_en && err_now && few;
	wire eof_ev = accept & rx_in.eof;
	wire short_fr = emd_en && few;
	wire byte_done = bitv && (par_slot || (bitcnt_q == 4'h7 && !rxpar_en)) && !kill;
	wire [7:0] byte_val = par_slot ? shift_q : {rx_in.bit_val, shift_q[7:1]};
	wire part = eof_ev && bitcnt_q != 4'h0 && !par_slot && allow_part && !short_fr;
	wire [7:0] part_val = shift_q >> (4'h8 - bitcnt_q);

	always_ff @(posedge clk_in) begin
		if (srst_in || !accept || !egt_in) begin
			egt_q <= '0;
		end else if (egt_q != EW'(EGT_LIMIT)) begin
			egt_q <= egt_q + EW'(1);
		end
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			shift_q <= 8'h00;
			bitcnt_q <= 4'h0;
			nbytes_q <= 2'h0;
			err_pend_q <= 1'b0;
			rx_busy_out <= 1'b0;
			fifo_out <= '0;
			fifo_reset_out <= 1'b0;
			rx_done_irq_out <= 1'b0;
			proto_err_out <= 1'b0;
			parity_err_out <= 1'b0;
		end else begin
			err_pend_q <= eof_ev && multi_en && !short_fr;
			fifo_reset_out <= kill || (eof_ev && short_fr);
			rx_done_irq_out <= eof_ev && !short_fr;
			proto_err_out <= egt_err;
			parity_err_out <= par_bad;
			if (err_pend_q) begin
				fifo_out <= {1'b1, error_reg_in};
			end else if (part) begin
				fifo_out <= {1'b1, part_val};
			end else begin
				fifo_out <= {byte_done, byte_val};
			end
			if (rx_start_in) begin
				rx_busy_out <= 1'b1;
			end else if (eof_ev && !multi_en) begin
				rx_busy_out <= 1'b0;
			end
			if (kill || eof_ev || sof_ev) begin
				bitcnt_q <= 4'h0;
				nbytes_q <= 2'h0;
			end else if (bitv) begin
				if (!par_slot) shift_q <= byte_val;
				bitcnt_q <= (byte_done || par_bad) ? 4'h0 : bitcnt_q + 4'h1;
				if (byte_done && few) nbytes_q <= nbytes_q + 2'h1;
			end
		end
	end

	AST_EMD_NO_IRQ: assert property (@(posedge clk_in) disable iff (srst_in)
		eof_ev && emd_en && nbytes_q < EMD_BYTES |=> fifo_reset_out && !rx_done_irq_out)
		else $error("suppressed frame signalled");
	AST_MULTI_ERRBYTE: assert property (@(posedge clk_in) disable iff (srst_in)
		eof_ev && multi_en && !short_fr |=> rx_busy_out ##1 fifo_out.wr && fifo_out.data == $past(error_reg_in))
		else $error("error byte missing");
	AST_EMD_KILL: assert property (@(posedge clk_in) disable iff (srst_in)
		kill |=> fifo_reset_out && !fifo_out.wr) else $error("disturbance kept");
	AST_EGT: assert property (@(posedge clk_in) disable iff (srst_in)
		egt_err |=> proto_err_out) else $error("guard error lost");
endmodule : rfc_frame_rx_ctrl

//--- rfc_card_model.sv
// Card side model: decoder pulses and subcarrier level seen by the block
module rfc_card_model
	import rfc_pkg::*;
(
	input wire logic clk_in,
	output rfc_rxin_type rx_out,
	output logic subc_out
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		rx_out = '0;
		subc_out = 1'h0;
	end
	// Start, nbits data bits LSB first, odd parity on full bytes, end
	task automatic send_frame(input logic [7:0] d, input logic par, input int nbits);
		rx_out <= rfc_rxin_type'(6'h08);
		@(posedge clk_in);
		for (int i = 0; i < nbits; i++) begin
			rx_out <= rfc_rxin_type'({1'h1, d[i], 4'h0});
			@(posedge clk_in);
		end
		if (par && nbits == 8) begin
			rx_out <= rfc_rxin_type'({1'h1, ~^d, 4'h0});
			@(posedge clk_in);
		end
		rx_out <= rfc_rxin_type'(6'h04);
		@(posedge clk_in);
		rx_out <= '0;
	endtask : send_frame
	// One decoder cycle; the caller ends a sequence with an idle value
	task automatic drive_pulse(input rfc_rxin_type v);
		rx_out <= v;
		@(posedge clk_in);
	endtask : drive_pulse
	task automatic set_subc(input logic v);
		subc_out <= v;
	endtask : set_subc
endmodule : rfc_card_model

//--- tb_top.sv
// Self-checking bench of the frame and receiver control block
module tb_top
	import rfc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_in, srst_in, avs_read_in, avs_write_in, avs_waitrequest_out;
	logic [7:0] avs_address_in, tx_data_in, error_reg_in;
	logic [31:0] avs_writedata_in, avs_readdata_out;
	logic [3:0] avs_byteenable_in;
	logic tx_valid_in, tx_last_in, tx_ready_out, rx_start_in, subc_in, egt_in;
	logic [2:0] tx_baud_in, rx_baud_out;
	logic [1:0] eof_pattern_in;
	rfc_sym_type tx_sym_out;
	rfc_rxin_type rx_in;
	rfc_fifo_type fifo_out;
	logic fifo_reset_out, rx_done_irq_out, frame_start_irq_out, proto_err_out, parity_err_out;
	logic eof_check_out, eof_type_b_out, rx_baud_ok_out, rx_busy_out, blank_out;
	int mismatches, tests_run, n_done, n_reset, n_start, n_perr, n_blank, n_proto;
	logic [7:0] fifo_q[$];
	logic [2:0] sym_q[$];
	rfc_frame_rx_ctrl #(.EGT_LIMIT(8)) rfc_frame_rx_ctrl_inst (.clk_in(clk_in), .srst_in(srst_in),
		.avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
		.avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
		.avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
		.tx_valid_in(tx_valid_in), .tx_data_in(tx_data_in), .tx_last_in(tx_last_in), .tx_baud_in(tx_baud_in),
		.tx_ready_out(tx_ready_out), .tx_sym_out(tx_sym_out), .rx_start_in(rx_start_in), .rx_in(rx_in),
		.subc_in(subc_in), .egt_in(egt_in), .eof_pattern_in(eof_pattern_in), .error_reg_in(error_reg_in),
		.fifo_out(fifo_out), .fifo_reset_out(fifo_reset_out), .rx_done_irq_out(rx_done_irq_out),
		.frame_start_irq_out(frame_start_irq_out), .proto_err_out(proto_err_out),
		.parity_err_out(parity_err_out), .eof_check_out(eof_check_out), .eof_type_b_out(eof_type_b_out),
		.rx_baud_out(rx_baud_out), .rx_baud_ok_out(rx_baud_ok_out), .rx_busy_out(rx_busy_out),
		.blank_out(blank_out));
	rfc_card_model rfc_card_model_inst (.clk_in(clk_in), .rx_out(rx_in), .subc_out(subc_in));
	initial begin
		clk_in = 1'h0;
		forever #2.5 clk_in = ~clk_in;
	end
	always @(posedge clk_in) begin
		if (fifo_out.wr === 1'h1) fifo_q.push_back(fifo_out.data);
		if (tx_sym_out.valid === 1'h1) sym_q.push_back({tx_sym_out.kind, tx_sym_out.bit_val});
		n_done += (rx_done_irq_out === 1'h1);
		n_reset += (fifo_reset_out === 1'h1);
		n_start += (frame_start_irq_out === 1'h1);
		n_perr += (parity_err_out === 1'h1);
		n_blank += (blank_out === 1'h1);
		n_proto += (proto_err_out === 1'h1);
	end
	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : complete_run
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		tests_run++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value at %0t ns: %s seen %0h expected %0h", $time, what, seen, exp);
		end
	endtask : check
	task automatic timed_out(input string what);
		mismatches++;
		$display("wrong value at %0t ns: no answer in %s", $time, what);
		complete_run();
	endtask : timed_out
	task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd, input logic [3:0] be,
		output logic [7:0] rd);
		int n;
		n = 0;
		avs_address_in <= {idx[5:0], 2'h0};
		avs_write_in <= wr;
		avs_read_in <= ~wr;
		avs_writedata_in <= {24'h000000, wd};
		avs_byteenable_in <= be;
		do begin
			@(posedge clk_in);
			n++;
		end while (avs_waitrequest_out !== 1'h0 && n < 20);
		if (avs_waitrequest_out !== 1'h0) timed_out("bus");
		rd = avs_readdata_out[7:0];
		avs_read_in <= 1'h0;
		avs_write_in <= 1'h0;
		@(posedge clk_in);
	endtask : bus
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		logic [7:0] x;
		bus(1'h1, idx, d, 4'hF, x);
	endtask : wr
	task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp, input string what);
		logic [7:0] x;
		bus(1'h0, idx, 8'h00, 4'hF, x);
		check(x, exp, what);
	endtask : rd_chk
	task automatic send_tx(input logic [7:0] d);
		int n;
		n = 0;
		tx_valid_in <= 1'h1;
		tx_data_in <= d;
		tx_last_in <= 1'h1;
		do begin
			@(posedge clk_in);
			n++;
		end while (tx_ready_out !== 1'h1 && n < 50);
		tx_valid_in <= 1'h0;
		do begin
			@(posedge clk_in);
			n++;
		end while (tx_ready_out !== 1'h1 && n < 100);
		if (tx_ready_out !== 1'h1) timed_out("transmit");
		repeat (3) @(posedge clk_in);
	endtask : send_tx
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic test_regs;
		logic [7:0] idx [4] = '{IDX_FRAME, IDX_SOFD, IDX_RECEIVE_CONTROL, IDX_BLANKING_COUNT};
		logic [7:0] msk [4] = '{FRAME_WMASK, SOFD_WMASK, 8'hFF, 8'hFF};
		logic [7:0] x;
		for (int i = 0; i < 4; i++) begin
			rd_chk(idx[i], RST_REG, "reset value");
			wr(idx[i], 8'hFF);
			rd_chk(idx[i], msk[i], "writable bits");
			wr(idx[i], RST_REG);
		end
		wr(8'h20, 8'hFF);
		rd_chk(8'h20, 8'h00, "unmapped");
		bus(1'h1, IDX_RECEIVE_CONTROL, 8'h5A, 4'hE, x);
		rd_chk(IDX_RECEIVE_CONTROL, 8'h00, "byte lane off");
		$display("test registers done");
	endtask : test_regs
	task automatic test_tx;
		logic [2:0] e[$];
		logic [7:0] d;
		logic m;
		d = 8'h03;
		for (int c = 0; c < 4; c++) begin
			e = {};
			if (c != 0) e.push_back({c[1:0], 1'h0});
			for (int b = 0; b < 8; b++) e.push_back({2'h0, d[b]});
			if (c[0]) e.push_back({2'h0, ~^d});
			if (c != 0) e.push_back({c[1:0], 1'h0});
			wr(IDX_FRAME, {c[0], 3'h0, c[1:0], c[1:0]});
			sym_q.delete();
			send_tx(d);
			check(sym_q.size(), e.size(), "symbol count");
			foreach (e[i]) begin
				m = (e[i][2:1] == 2'h0);
				check({sym_q[i][2:1], sym_q[i][0] & m}, {e[i][2:1], e[i][0] & m}, "symbol");
			end
		end
		$display("test transmit done");
	endtask : test_tx
	task automatic test_rx(input logic multi, input logic par, input logic emd);
		int d0, r0, s0, p0;
		wr(IDX_FRAME, {1'h0, par, 6'h00});
		wr(IDX_RECEIVE_CONTROL, {1'h0, multi, 2'h0, emd, 3'h4});
		fifo_q.delete();
		d0 = n_done;
		r0 = n_reset;
		s0 = n_start;
		p0 = n_perr;
		rx_start_in <= 1'h1;
		@(posedge clk_in);
		rx_start_in <= 1'h0;
		rfc_card_model_inst.send_frame(8'hA5, par, 8);
		repeat (6) @(posedge clk_in);
		check(n_start - s0, 1, "frame start request");
		check(n_perr - p0, 0, "parity error");
		if (emd) begin
			check(n_reset - r0, 1, "fifo reset");
			check(n_done - d0, 0, "receive done");
			fifo_q.delete();
			r0 = n_reset;
			rx_start_in <= 1'h1;
			@(posedge clk_in);
			rx_start_in <= 1'h0;
			rfc_card_model_inst.drive_pulse(rfc_rxin_type'(6'h08));
			rfc_card_model_inst.drive_pulse(rfc_rxin_type'(6'h02));
			rfc_card_model_inst.drive_pulse('0);
			repeat (3) @(posedge clk_in);
			check(n_reset - r0, 1, "collision reset");
			check(fifo_q.size(), 0, "collision data");
		end else begin
			check(fifo_q.size(), multi ? 2 : 1, "fifo count");
			check(fifo_q[0], 8'hA5, "fifo data");
			if (multi) check(fifo_q[1], error_reg_in, "error byte");
			check(rx_busy_out, multi, "still receiving");
			check(n_done - d0, 1, "receive done");
		end
		$display("test receive done");
	endtask : test_rx
	task automatic test_part(input logic allow);
		wr(IDX_RECEIVE_CONTROL, {allow, 7'h04});
		fifo_q.delete();
		rx_start_in <= 1'h1;
		@(posedge clk_in);
		rx_start_in <= 1'h0;
		rfc_card_model_inst.send_frame(8'h0B, 1'h0, 4);
		repeat (6) @(posedge clk_in);
		check(fifo_q.size(), allow, "partial count");
		if (allow) check(fifo_q[0], 8'h0B, "partial byte");
		$display("test partial byte done");
	endtask : test_part
	task automatic test_egt(input logic chk);
		int p0;
		wr(IDX_RECEIVE_CONTROL, {3'h0, chk, 4'h4});
		p0 = n_proto;
		rx_start_in <= 1'h1;
		@(posedge clk_in);
		rx_start_in <= 1'h0;
		egt_in <= 1'h1;
		repeat (12) @(posedge clk_in);
		egt_in <= 1'h0;
		repeat (2) @(posedge clk_in);
		check(n_proto - p0, chk, "guard error");
		$display("test guard time done");
	endtask : test_egt
	task automatic test_status;
		int s0;
		rd_chk(IDX_SOFD, 8'h34, "start seen");
		wr(IDX_SOFD, 8'h24);
		rd_chk(IDX_SOFD, 8'h24, "flags cleared");
		s0 = n_start;
		rfc_card_model_inst.set_subc(1'h1);
		repeat (6) @(posedge clk_in);
		rd_chk(IDX_SOFD, 8'h27, "subcarrier on");
		check(n_start - s0, 1, "subcarrier request");
		rfc_card_model_inst.set_subc(1'h0);
		repeat (6) @(posedge clk_in);
		rd_chk(IDX_SOFD, 8'h26, "subcarrier gone");
		wr(IDX_SOFD, 8'h00);
		rd_chk(IDX_SOFD, 8'h00, "flag cleared");
		$display("test status done");
	endtask : test_status
	task automatic test_cfg;
		for (int b = 0; b < 8; b++) begin
			eof_pattern_in <= b[2:1];
			wr(IDX_RECEIVE_CONTROL, {2'h0, b[0], 2'h0, b[2:0]});
			repeat (2) @(posedge clk_in);
			check(eof_type_b_out, b[0], "end type");
			check(eof_check_out, b[0] | (b[2:1] != 0), "end check");
			check(rx_baud_out, b[2:0], "baud");
			check(rx_baud_ok_out, b[2:0] >= BAUD_MIN, "baud in range");
		end
		$display("test configuration done");
	endtask : test_cfg
	task automatic test_blank(input logic unit, input logic [2:0] baud);
		int n, ticks, expc, b0;
		tx_baud_in <= baud;
		wr(IDX_FRAME, 8'h00);
		wr(IDX_BLANKING_COUNT, {unit, 7'h02});
		ticks = 2 * (unit ? (HALF_BIT_FASTEST << (7 - baud)) : UNIT_CARRIER);
		expc = ticks * CLK_KHZ / CARRIER_KHZ;
		b0 = n_blank;
		n = 0;
		send_tx(8'h00);
		do begin
			@(posedge clk_in);
			n++;
		end while ((blank_out !== 1'h0 || n_blank == b0) && n < 3000);
		if (blank_out !== 1'h0) timed_out("blanking");
		check(n_blank - b0 >= expc - 3 && n_blank - b0 <= expc + 3, 1'h1, "blank length");
		wr(IDX_BLANKING_COUNT, 8'h00);
		$display("test blanking done");
	endtask : test_blank
	initial begin
		srst_in = 1'h1;
		{avs_read_in, avs_write_in, tx_valid_in, tx_last_in, rx_start_in, egt_in} = 6'h00;
		avs_address_in = 8'h00;
		avs_writedata_in = 32'h00000000;
		avs_byteenable_in = 4'hF;
		tx_data_in = 8'h00;
		tx_baud_in = 3'h7;
		eof_pattern_in = 2'h0;
		error_reg_in = 8'h5A;
		repeat (12) @(posedge clk_in);
		srst_in <= 1'h0;
		@(posedge clk_in);
		test_regs();
		test_tx();
		wr(IDX_SOFD, 8'h24);
		test_rx(1'h0, 1'h0, 1'h0);
		test_rx(1'h0, 1'h1, 1'h0);
		test_rx(1'h1, 1'h1, 1'h0);
		test_rx(1'h0, 1'h0, 1'h1);
		test_part(1'h1);
		test_part(1'h0);
		test_egt(1'h1);
		test_egt(1'h0);
		test_status();
		test_cfg();
		test_blank(1'h0, 3'h7);
		test_blank(1'h1, 3'h7);
		test_blank(1'h1, 3'h5);
		complete_run();
	end
endmodule : tb_top
